// [scan_pkg.sv]
// package: constants for the display scan timing and drive control block
package scan_pkg;
  // duty selection codes
  localparam logic [2:0] DUTY_65 = 3'h0;
  localparam logic [2:0] DUTY_49 = 3'h1;
  localparam logic [2:0] DUTY_33 = 3'h2;
  localparam logic [2:0] DUTY_55 = 3'h3;
  localparam logic [2:0] DUTY_53 = 3'h4;
  // last row index for each duty
  localparam logic [5:0] LAST_65 = 6'h3F;
  localparam logic [5:0] LAST_49 = 6'h2F;
  localparam logic [5:0] LAST_33 = 6'h1F;
  localparam logic [5:0] LAST_55 = 6'h35;
  localparam logic [5:0] LAST_53 = 6'h33;
  // row pin count and column channel count
  localparam int unsigned ROW_PINS  = 64;
  localparam int unsigned COLS      = 132;
  localparam int unsigned ROW_AW    = 6;
  // power control bit positions
  localparam int unsigned PWR_BOOST = 2;
  localparam int unsigned PWR_REG   = 1;
  localparam int unsigned PWR_FOLL  = 0;
  localparam logic [2:0] PWR_RESET  = 3'h0;
  localparam logic [5:0] VOL_RESET  = 6'h20;
  // display clock divide: display clocks per line
  localparam logic [3:0] LINE_TICKS = 4'h4;
  // drive level codes for a driver channel
  localparam logic [1:0] LVL_OFF_POS = 2'h0;
  localparam logic [1:0] LVL_OFF_NEG = 2'h1;
  localparam logic [1:0] LVL_ON_POS  = 2'h2;
  localparam logic [1:0] LVL_ON_NEG  = 2'h3;
endpackage : scan_pkg

// [row_fifo.sv]
// module: small fifo that buffers display rows between fetch and latch
`timescale 1ns/10ps
`default_nettype none
module row_fifo #(
  parameter int unsigned WIDTH = 132,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // write side
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             wvalid_i,
  output logic                  wready_o,
  // read side
  output logic      [WIDTH-1:0] rdata_o,
  output logic                  rvalid_o,
  input  wire logic             rready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic [WIDTH-1:0] rdata_reg, rdata_next;
  logic             rvalid_reg, rvalid_next;
  logic             wready_reg, wready_next;
  logic             push, pop;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    mem_next    = mem_reg;
    wp_next     = wp_reg;
    rp_next     = rp_reg;
    cnt_next    = cnt_reg;
    rdata_next  = rdata_reg;
    rvalid_next = rvalid_reg;
    // output register is refilled when empty or being taken
    pop  = (cnt_reg != '0) && (!rvalid_reg || rready_i);
    push = wvalid_i && wready_reg;
    if (rvalid_reg && rready_i) begin
      rvalid_next = 1'b0;
    end
    if (pop) begin
      rdata_next  = mem_reg[rp_reg];
      rvalid_next = 1'b1;
      rp_next     = rp_reg + 1'b1;
    end
    if (push) begin
      mem_next[wp_reg] = wdata_i;
      wp_next          = wp_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // ready is registered so the write side never sees a combinational path
    wready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg     <= '0;
      rp_reg     <= '0;
      cnt_reg    <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      wready_reg <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wp_reg     <= wp_next;
      rp_reg     <= rp_next;
      cnt_reg    <= cnt_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      wready_reg <= wready_next;
      mem_reg    <= mem_next;
    end
  end

  assign wready_o = wready_reg;
  assign rdata_o  = rdata_reg;
  assign rvalid_o = rvalid_reg;
endmodule // row_fifo
`default_nettype wire

// [lcd_scan_ctrl.sv]
// module: display scan timing, row sequencing, drive selection and power control
// Summary of operation
// - timing strobes for line advance and latch load come from display clock only
// - each row is latched with the display clock then driven to column outputs
// - row fetch uses its own port, independent of host ram traffic
// - row timing and polarity signal generated; polarity alternates over two frames
// - scan direction input selects ascending or descending row order
// - normal scan runs row 0 to last row of the duty; reverse runs down
// - reduced duties split lines over lowest and highest pin groups, mirrored in reverse
// - each driver level comes from latched data, row scan and polarity
// - three power bits switch booster, regulator, follower; one means on
// - supply stages are enabled only in master operation
// - regulator takes a 64-level volume setting held by the device
// - clock source select high enables oscillator in master operation only, low stops it for external tick
// - on/off, reverse and all-on modify latch output only, never ram
// - first scanned line follows start line; changes scroll the image
`timescale 1ns/10ps
`default_nettype none
module lcd_scan_ctrl
  import scan_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // clock source
  input  wire logic                clock_source_select_i,
  input  wire logic                external_tick_input_i,
  input  wire logic                master_i,
  output logic                     osc_enable_o,
  // display configuration
  input  wire logic [2:0]          duty_sel_i,
  input  wire logic                scan_reverse_i,
  input  wire logic [5:0]          start_line_i,
  input  wire logic                display_on_i,
  input  wire logic                display_invert_i,
  input  wire logic                all_on_i,
  // display ram read port
  output logic [5:0]               ram_line_o,
  output logic                     ram_req_o,
  input  wire logic [COLS-1:0]     ram_data_i,
  input  wire logic                ram_valid_i,
  output logic                     ram_ready_o,
  input  wire logic                icon_data_i,
  // power control
  input  wire logic [2:0]          power_ctrl_i,
  input  wire logic                power_wr_i,
  input  wire logic [5:0]          volume_i,
  input  wire logic                volume_wr_i,
  output logic                     booster_en_o,
  output logic                     regulator_en_o,
  output logic                     follower_en_o,
  output logic [5:0]               reference_voltage_o,
  // panel drive
  output logic                     ac_polarity_signal_o,
  output logic [COLS-1:0][1:0]     column_driver_output_o,
  output logic [ROW_PINS-1:0][1:0] row_driver_o,
  output logic [1:0]               icon_row_o,
  output logic                     line_strobe_o
);

  // decode last row index of a duty
  function automatic logic [5:0] last_row(input logic [2:0] d);
    unique case (d)
      DUTY_49: last_row = LAST_49;
      DUTY_33: last_row = LAST_33;
      DUTY_55: last_row = LAST_55;
      DUTY_53: last_row = LAST_53;
      default: last_row = LAST_65;
    endcase
  endfunction

  // map scan position to physical row pin
  function automatic logic [5:0] row_pin(input logic [5:0] pos, input logic [2:0] d,
                                         input logic rev);
    logic [5:0] lst;
    logic [5:0] half;
    logic [5:0] p;
    lst  = last_row(d);
    half = 6'((7'(lst) + 7'h01) >> 1);
    p    = rev ? (lst - pos) : pos;
    if (d == DUTY_65 || p < half) begin
      row_pin = p;
    end else begin
      row_pin = 6'(7'h40 - 7'(lst) + 7'(p) - 7'h01);
    end
  endfunction

  // ************************************************
  // tick source and timing
  // ************************************************
  logic       tick_prev_reg, tick_prev_next;
  logic       tick;
  logic [3:0] div_reg, div_next;
  logic [5:0] pos_reg, pos_next;
  logic       icon_phase_reg, icon_phase_next;
  logic       pol_reg, pol_next;
  logic       strobe_reg, strobe_next;
  logic       osc_reg, osc_next;

  always_comb begin
    tick_prev_next = external_tick_input_i;
    // oscillator mode ticks every clock; external mode ticks on rising tick edge
    tick     = clock_source_select_i ? 1'b1 : (external_tick_input_i && !tick_prev_reg);
    osc_next = clock_source_select_i && master_i;
    div_next        = div_reg;
    pos_next        = pos_reg;
    icon_phase_next = icon_phase_reg;
    pol_next        = pol_reg;
    strobe_next     = 1'b0;
    if (tick) begin
      if (div_reg == LINE_TICKS - 4'h1) begin
        div_next    = '0;
        strobe_next = 1'b1;
        if (icon_phase_reg) begin
          icon_phase_next = 1'b0;
          pos_next        = '0;
          pol_next        = !pol_reg;
        end else if (pos_reg >= last_row(duty_sel_i)) begin
          icon_phase_next = 1'b1;
        end else begin
          pos_next = pos_reg + 6'h01;
        end
      end else begin
        div_next = div_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_prev_reg  <= 1'b0;
      div_reg        <= '0;
      pos_reg        <= '0;
      icon_phase_reg <= 1'b0;
      pol_reg        <= 1'b0;
      strobe_reg     <= 1'b0;
      osc_reg        <= 1'b0;
    end else begin
      tick_prev_reg  <= tick_prev_next;
      div_reg        <= div_next;
      pos_reg        <= pos_next;
      icon_phase_reg <= icon_phase_next;
      pol_reg        <= pol_next;
      strobe_reg     <= strobe_next;
      osc_reg        <= osc_next;
    end
  end

  // ************************************************
  // row fetch through fifo
  // ************************************************
  logic [COLS-1:0] fifo_data;
  logic            fifo_valid;
  logic            fifo_take;

  row_fifo #(
    .WIDTH (COLS),
    .DEPTH (FIFO_DEPTH)
  ) u_row_fifo (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .wdata_i  (ram_data_i),
    .wvalid_i (ram_valid_i),
    .wready_o (ram_ready_o),
    .rdata_o  (fifo_data),
    .rvalid_o (fifo_valid),
    .rready_i (fifo_take)
  );

  logic [5:0] line_reg, line_next;
  logic       req_reg, req_next;

  always_comb begin
    // ram line address offset by start line so changing it scrolls
    // next row is asked for at this strobe, giving a slow ram a whole line to answer;
    // limitation: the first line after reset shows the cleared latch
    line_next = strobe_next ? 6'(start_line_i + pos_next) : line_reg;
    req_next  = strobe_next && !icon_phase_next;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_reg <= '0;
      req_reg  <= 1'b0;
    end else begin
      line_reg <= line_next;
      req_reg  <= req_next;
    end
  end

  // ************************************************
  // display latch and drive selection
  // ************************************************
  logic [COLS-1:0]            latch_reg, latch_next;
  logic                       icon_reg, icon_next;
  logic [5:0]                 act_pin_reg, act_pin_next;
  logic                       act_icon_reg, act_icon_next;
  logic [COLS-1:0][1:0]       col_next;
  logic [COLS-1:0][1:0]       col_reg;
  logic [ROW_PINS-1:0][1:0]   row_next;
  logic [ROW_PINS-1:0][1:0]   row_reg;
  logic [1:0]                 iconr_reg, iconr_next;

  // strobe consumes one buffered row; latch holds it for the line
  assign fifo_take = strobe_next && !icon_phase_reg;

  always_comb begin
    latch_next    = latch_reg;
    icon_next     = icon_reg;
    act_pin_next  = act_pin_reg;
    act_icon_next = act_icon_reg;
    if (strobe_next) begin
      if (!icon_phase_reg && fifo_valid) begin
        latch_next = fifo_data;
      end
      icon_next     = icon_data_i;
      act_icon_next = icon_phase_reg;
      act_pin_next  = row_pin(pos_reg, duty_sel_i, scan_reverse_i);
    end
  end

  // pixel on decision applies modes to latched data only, ram untouched
  function automatic logic pix_on(input logic d);
    pix_on = !display_on_i ? 1'b0 : (all_on_i ? 1'b1 : (d ^ display_invert_i));
  endfunction

  generate
    for (genvar c = 0; c < COLS; c++) begin : g_col
      always_comb begin
        col_next[c] = act_icon_reg ? (pix_on(icon_reg) ? {1'b1, pol_reg} : {1'b0, pol_reg})
                    : (pix_on(latch_reg[c]) ? {1'b1, pol_reg} : {1'b0, pol_reg});
      end
    end
    for (genvar r = 0; r < ROW_PINS; r++) begin : g_row
      always_comb begin
        row_next[r] = (!act_icon_reg && act_pin_reg == 6'(r)) ? {1'b1, pol_reg}
                    : {1'b0, pol_reg};
      end
    end
  endgenerate

  assign iconr_next = {act_icon_reg, pol_reg};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_reg    <= '0;
      icon_reg     <= 1'b0;
      act_pin_reg  <= '0;
      act_icon_reg <= 1'b0;
      col_reg      <= '0;
      row_reg      <= '0;
      iconr_reg    <= '0;
    end else begin
      latch_reg    <= latch_next;
      icon_reg     <= icon_next;
      act_pin_reg  <= act_pin_next;
      act_icon_reg <= act_icon_next;
      col_reg      <= col_next;
      row_reg      <= row_next;
      iconr_reg    <= iconr_next;
    end
  end

  // ************************************************
  // power control and volume
  // ************************************************
  logic [2:0] pwr_reg, pwr_next;
  logic [5:0] vol_reg, vol_next;
  logic [2:0] en_reg, en_next;

  always_comb begin
    // setting lands at once; scan state is not touched
    pwr_next = power_wr_i ? power_ctrl_i : pwr_reg;
    vol_next = volume_wr_i ? volume_i : vol_reg;
    en_next  = master_i ? pwr_next : 3'h0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_reg <= PWR_RESET;
      vol_reg <= VOL_RESET;
      en_reg  <= PWR_RESET;
    end else begin
      pwr_reg <= pwr_next;
      vol_reg <= vol_next;
      en_reg  <= en_next;
    end
  end

  assign osc_enable_o           = osc_reg;
  assign ram_line_o             = line_reg;
  assign ram_req_o              = req_reg;
  assign booster_en_o           = en_reg[PWR_BOOST];
  assign regulator_en_o         = en_reg[PWR_REG];
  assign follower_en_o          = en_reg[PWR_FOLL];
  assign reference_voltage_o    = vol_reg;
  assign ac_polarity_signal_o   = pol_reg;
  assign column_driver_output_o = col_reg;
  assign row_driver_o           = row_reg;
  assign icon_row_o             = iconr_reg;
  assign line_strobe_o          = strobe_reg;
endmodule // lcd_scan_ctrl
`default_nettype wire

// [lcd_scan_ctrl_assertions.sv]
// checker: port-level properties of the scan control block
`timescale 1ns/10ps
`default_nettype none
module lcd_scan_ctrl_assertions
  import scan_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // inputs watched
  input  wire logic                     clock_source_select_i,
  input  wire logic                     master_i,
  input  wire logic                     display_on_i,
  input  wire logic [2:0]               power_ctrl_i,
  input  wire logic                     power_wr_i,
  input  wire logic [5:0]               volume_i,
  input  wire logic                     volume_wr_i,
  // outputs watched
  input  wire logic                     osc_enable_o,
  input  wire logic                     ram_req_o,
  input  wire logic                     booster_en_o,
  input  wire logic                     regulator_en_o,
  input  wire logic                     follower_en_o,
  input  wire logic [5:0]               reference_voltage_o,
  input  wire logic                     ac_polarity_signal_o,
  input  wire logic [COLS-1:0][1:0]     column_driver_output_o,
  input  wire logic [ROW_PINS-1:0][1:0] row_driver_o,
  input  wire logic                     line_strobe_o
);
  // ****************
  // helper logic
  // ****************
  logic [ROW_PINS-1:0] row_sel;
  logic                any_on;
  logic [2:0]          pwr;
  always_comb begin
    any_on = 1'b0;
    for (int i = 0; i < COLS; i++) begin
      any_on |= column_driver_output_o[i][1];
    end
    for (int i = 0; i < ROW_PINS; i++) begin
      row_sel[i] = row_driver_o[i][1];
    end
  end
  assign pwr = {booster_en_o, regulator_en_o, follower_en_o};
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ****************
  // properties
  // ****************
  strobe_gap_a: assert property (line_strobe_o |=> !line_strobe_o [*3])
    else $error("line strobe closer than four cycles");
  // only judged while the internal tick runs; external ticks are slower
  strobe_period_a: assert property (line_strobe_o && clock_source_select_i ##1
    clock_source_select_i [*4] |-> line_strobe_o)
    else $error("line period not four ticks");
  req_pulse_a: assert property (ram_req_o |=> !ram_req_o [*3])
    else $error("row fetch request repeated within a line");
  osc_follow_a: assert property (1 |=> osc_enable_o == $past(clock_source_select_i & master_i))
    else $error("oscillator enable wrong");
  stage_off_a: assert property (!master_i |=> pwr == 3'h0)
    else $error("supply stage on without master");
  power_set_a: assert property (power_wr_i && master_i ##1 !power_wr_i && master_i
    |=> pwr == $past(power_ctrl_i, 2))
    else $error("power stages do not follow setting");
  volume_set_a: assert property (volume_wr_i ##1 !volume_wr_i
    |=> reference_voltage_o == $past(volume_i, 2))
    else $error("volume not stored");
  polarity_hold_a: assert property ($changed(ac_polarity_signal_o)
    |=> $stable(ac_polarity_signal_o) [*8])
    else $error("polarity toggled inside a frame");
  off_blank_a: assert property (!display_on_i [*8] |-> !any_on)
    else $error("pixel on while display off");
  one_row_a: assert property ($onehot0(row_sel))
    else $error("more than one row selected");
endmodule // lcd_scan_ctrl_assertions
bind lcd_scan_ctrl lcd_scan_ctrl_assertions i_chk (.*);
`default_nettype wire

// [ram_model.sv]
// partner: display ram read side answering row fetch requests
`timescale 1ns/10ps
`default_nettype none
module ram_model
  import scan_pkg::*;
(
  // clock and mode
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  // fetch port
  input  wire logic [5:0] line_i,
  input  wire logic       req_i,
  input  wire logic       ready_i,
  output logic [COLS-1:0] data_o,
  output logic            valid_o
);
  // ****************
  // row server
  // ****************
  logic [COLS-1:0] last;
  initial begin
    valid_o = 1'b0;
    data_o  = '0;
    forever begin
      @(posedge clk_i);
      #1;
      if (req_i) begin
        last = {22{line_i}};
        if (slow_i) begin
          @(posedge clk_i);
          #1;
        end
        data_o  = last;
        valid_o = 1'b1;
        @(posedge clk_i iff ready_i);
        #1;
        valid_o = 1'b0;
        // released bus shows junk so a stale row never passes
        data_o  = ~last;
      end
    end
  end
endmodule // ram_model
`default_nettype wire

// [test_lcd_scan_timing_and_drive_control.sv]
// testbench: power table, scan order, drive data, clock source and fifo
`timescale 1ns/10ps
`default_nettype none
module test_lcd_scan_timing_and_drive_control
  import scan_pkg::*;
;
  // ****************
  // signals
  // ****************
  logic                     clk_i, resetn_i, css, ext_tick, master, scan_rev, icon;
  logic                     disp_on, disp_inv, all_on, pwr_wr, vol_wr, slow;
  logic [2:0]               duty, pwr, en;
  logic [5:0]               start, vol, vref, ram_line;
  logic [COLS-1:0]          ram_data;
  logic                     ram_valid, ram_ready, ram_req, strobe, osc_en, acp;
  logic [COLS-1:0][1:0]     cols;
  logic [ROW_PINS-1:0][1:0] rows;
  logic [1:0]               icon_row;
  logic                     old_pol;
  int                       error_cnt, n_compared, cyc;
  // rows: {master, setting, expected stages}
  localparam logic [6:0] PT [6] = '{7'h7F, 7'h5B, 7'h49, 7'h40, 7'h64, 7'h38};

  lcd_scan_ctrl #(.FIFO_DEPTH(4)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .clock_source_select_i(css),
    .external_tick_input_i(ext_tick), .master_i(master), .osc_enable_o(osc_en),
    .duty_sel_i(duty), .scan_reverse_i(scan_rev), .start_line_i(start),
    .display_on_i(disp_on), .display_invert_i(disp_inv), .all_on_i(all_on),
    .ram_line_o(ram_line), .ram_req_o(ram_req), .ram_data_i(ram_data),
    .ram_valid_i(ram_valid), .ram_ready_o(ram_ready), .icon_data_i(icon),
    .power_ctrl_i(pwr), .power_wr_i(pwr_wr), .volume_i(vol), .volume_wr_i(vol_wr),
    .booster_en_o(en[2]), .regulator_en_o(en[1]), .follower_en_o(en[0]),
    .reference_voltage_o(vref), .ac_polarity_signal_o(acp),
    .column_driver_output_o(cols), .row_driver_o(rows), .icon_row_o(icon_row),
    .line_strobe_o(strobe));
  ram_model i_ram (.clk_i(clk_i), .slow_i(slow), .line_i(ram_line), .req_i(ram_req),
    .ready_i(ram_ready), .data_o(ram_data), .valid_o(ram_valid));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [COLS-1:0] g, input logic [COLS-1:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // sample mid-line, once the drive registers have settled
  task automatic next_line();
    @(posedge clk_i iff strobe);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic scan(input logic [2:0] d, input int n, input logic r);
    logic [COLS-1:0] on_v, sel_v;
    int k;
    duty     = d;
    scan_rev = r;
    repeat (2) begin
      do next_line(); while (icon_row[1] !== 1'b1);
    end
    for (int j = 0; j < n; j++) begin
      next_line();
      on_v  = '0;
      sel_v = '0;
      for (int i = 0; i < COLS; i++) on_v[i] = cols[i][1];
      for (int i = 0; i < ROW_PINS; i++) sel_v[i] = rows[i][1];
      k = r ? n - 1 - j : j;
      chk(sel_v, 64'h1 << (k < n / 2 ? k : k + ROW_PINS - n));
      if (!r) chk(on_v, {22{6'(start + j)}} ^ {COLS{disp_inv}});
    end
    $display("scan duty %0d reverse %0d done", d, r);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    resetn_i = 1'b0; css = 1'b1; ext_tick = 1'b0; master = 1'b1; scan_rev = 1'b0;
    icon = 1'b1; disp_on = 1'b1; disp_inv = 1'b0; all_on = 1'b0; slow = 1'b0;
    duty = DUTY_65; pwr = 3'h0; pwr_wr = 1'b0; vol = 6'h00; vol_wr = 1'b0;
    start = 6'h00; old_pol = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(negedge clk_i);
    chk({vref, en, ram_ready}, {VOL_RESET, PWR_RESET, 1'b1});
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    // power writes land while the scan keeps running
    foreach (PT[i]) begin
      master = PT[i][6];
      pwr    = PT[i][5:3];
      pwr_wr = 1'b1;
      @(negedge clk_i);
      pwr_wr = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({osc_en, en}, {PT[i][6], PT[i][2:0]});
    end
    master = 1'b1;
    vol    = 6'h3F;
    vol_wr = 1'b1;
    @(negedge clk_i);
    vol    = 6'h05;
    @(negedge clk_i);
    vol_wr = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(vref, 6'h05);
    $display("power and volume done");
    scan(DUTY_65, 64, 1'b0);
    scan(DUTY_65, 64, 1'b1);
    start = 6'h2A;
    disp_inv = 1'b1;
    slow = 1'b1;
    scan(DUTY_33, 32, 1'b0);
    start = 6'h00;
    disp_inv = 1'b0;
    slow = 1'b0;
    scan(DUTY_49, 48, 1'b1);
    scan(DUTY_55, 54, 1'b0);
    scan(DUTY_53, 52, 1'b1);
    all_on = 1'b1;
    repeat (2) next_line();
    for (int i = 0; i < COLS; i++) chk(cols[i][1], 1'b1);
    all_on = 1'b0;
    disp_on = 1'b0;
    repeat (2) next_line();
    for (int i = 0; i < COLS; i++) chk(cols[i][1], 1'b0);
    disp_on = 1'b1;
    $display("latch modes done");
    css = 1'b0;
    fork
      repeat (64) begin
        repeat (4) @(negedge clk_i);
        ext_tick = ~ext_tick;
      end
      begin
        repeat (2) @(posedge clk_i iff strobe);
        cyc = 0;
        do begin
          @(posedge clk_i);
          cyc++;
        end while (strobe !== 1'b1);
        chk(osc_en, 1'b0);
        chk(COLS'(cyc), COLS'(32));
      end
    join
    $display("external tick done");
    // icon line has no row pin and opens the new polarity frame; fifo never backs up
    css = 1'b1;
    do begin
      old_pol = acp;
      next_line();
    end while (icon_row[1] !== 1'b1);
    chk({icon_row, cols[0]}, {1'b1, ~old_pol, 1'b1, ~old_pol});
    chk({acp, rows[0][1], rows[ROW_PINS-1][1], ram_line}, {~old_pol, 2'b00, 6'h00});
    next_line();
    chk({ram_ready, rows[ROW_PINS-1][1], ram_line}, {1'b1, 1'b1, 6'h01});
    chk({acp, rows[ROW_PINS-1][0]}, {~old_pol, ~old_pol});
    $display("icon line and fifo done");
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule // test_lcd_scan_timing_and_drive_control
`default_nettype wire
